// file: verilog/ttc_trail_trace.sv
// trail trace controller top: register port, receive trace processing
// What this block does
// RULE1: transmit identifier kept in 16-byte store, separate write and read pointers.
// RULE2: transmit store has no reset and keeps contents through both resets.
// RULE3: bytes shift msb first; first received bit lands in bit 7.
// RULE4: first sent bit from bit 7, or bit 0 with reorder on.
// RULE5: alignment insertion forces first bit: one on byte 0, zero otherwise.
// RULE6: transmit inversion applied after reordering and alignment insertion.
// RULE7: transmit idle sends all-zero identifier data.
// RULE8: receive inversion applied before alignment, extraction and comparison.
// RULE9: align on a one, confirm next fifteen first bits are zero.
// RULE10: alignment off stores bytes in sequence from any starting byte.
// RULE11: identifier stored in order, aligned first byte at location zero.
// RULE12: same nonzero identifier five times, differing from held, updates held.
// RULE13: idle after five zero identifiers; ends on five nonzero or unstable.
// RULE14: unstable after eight misses; ends on five nonzero or idle.
// RULE15: mismatch compares seven data bits per byte, ignoring alignment bit.
// RULE16: comparison switchable and forced off without receive alignment.
// RULE17: held identifier invalid after reset, so no mismatch until update.
// RULE18: first received bit in bit 7, or bit 0 with reorder on.
// RULE19: alarms force received data to all ones.
// RULE20: storage reachable from either side while the other side is idle.
// RULE21: software loads all sixteen expected bytes before trusting mismatch.
// RULE22: receive storage holds current, held and expected identifiers.
// RULE23: condition changes and identifier change latched as status bits.
`timescale 1ns/10ps
module ttc_trail_trace (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_datapath_reset_n,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    input  wire logic       i_rx_bit,
    input  wire logic       i_rx_bit_en,
    input  wire logic       i_signal_loss,
    input  wire logic       i_frame_loss,
    input  wire logic       i_alarm_indication,
    input  wire logic       i_tx_bit_en,
    output logic            o_tx_bit,
    output logic            o_rx_idle,
    output logic            o_identifier_unstable,
    output logic            o_identifier_mismatch
);
    import ttc_pkg::*;

    ttc_rx_state_t        s;
    ttc_rx_state_t        next_s;
    logic                 rst_n;
    logic [3:0]           page;
    logic [3:0]           off;
    logic [7:0]           cur_mem  [ID_BYTES];
    logic [7:0]           held_mem [ID_BYTES];
    logic [7:0]           exp_mem  [ID_BYTES];
    logic                 byte_vld;
    logic [7:0]           rx_byte;
    logic                 first_bit;
    logic [7:0]           tx_rd;
    logic                 wr_cur;
    logic [3:0]           wr_idx;
    logic                 cmp_on;
    logic [7:0]           cmp_mask;
    logic [ID_BYTES-1:0]  diff;
    logic                 rx_alarm;

    assign rst_n = i_rst_n & i_datapath_reset_n;
    assign page  = i_addr[7:4];
    assign off   = i_addr[3:0];
    assign rx_alarm = i_signal_loss | i_frame_loss | i_alarm_indication;

    ttc_rx_deser u_deser (
        .i_ref_clk    (i_ref_clk),
        .i_rst_n      (rst_n),
        .i_bit        (i_rx_bit),
        .i_bit_en     (i_rx_bit_en),
        .i_invert     (s.ctrl[CTL_RX_INVERT]),
        .i_force_ones (rx_alarm),
        .i_reorder    (s.ctrl[CTL_RX_REORDER]),
        .o_byte_vld   (byte_vld),
        .o_byte       (rx_byte),
        .o_first_bit  (first_bit)
    );

    // transmit store is written straight from the register port
    ttc_tx_proc u_tx (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (rst_n),
        .i_wr_en   (i_wr && page == PAGE_TX),
        .i_wr_idx  (off),
        .i_wdata   (i_wdata),
        .i_rd_idx  (off),
        .o_rd_data (tx_rd),
        .i_bit_en  (i_tx_bit_en),
        .i_align   (s.ctrl[CTL_TX_ALIGN]),
        .i_reorder (s.ctrl[CTL_TX_REORDER]),
        .i_invert  (s.ctrl[CTL_TX_INVERT]),
        .i_idle    (s.ctrl[CTL_TX_IDLE]),
        .o_tx_bit  (o_tx_bit)
    );

    // expected comparison ignores the alignment bit position
    assign cmp_mask = s.ctrl[CTL_RX_REORDER] ? MASK_LSB_ALIGN
                                             : MASK_MSB_ALIGN;  // [RULE15]
    assign cmp_on = s.ctrl[CTL_CMP_EN] & s.ctrl[CTL_RX_ALIGN];  // [RULE16]

    for (genvar g = 0; g < ID_BYTES; g++) begin : g_cmp
        assign diff[g] = |((held_mem[g] ^ exp_mem[g]) & cmp_mask); // [RULE15]
    end

    always_comb begin
        logic       base;
        logic       f_same;
        logic       f_zero;
        logic       f_held;
        logic       done;
        logic       nz;
        logic       miss;
        logic       idle_set;
        logic       unst_set;
        logic [2:0] same_n;
        logic [2:0] zero_n;
        logic [2:0] nz_n;
        logic [3:0] miss_n;
        logic [3:0] lat_set;
        logic [3:0] lat_clr;
        base     = 1'b0;
        f_same   = 1'b0;
        f_zero   = 1'b0;
        f_held   = 1'b0;
        done     = 1'b0;
        nz       = 1'b0;
        miss     = 1'b0;
        idle_set = 1'b0;
        unst_set = 1'b0;
        same_n   = s.same_cnt;
        zero_n   = s.zero_cnt;
        nz_n     = s.nz_cnt;
        miss_n   = s.miss_cnt;
        lat_set  = 4'h0;
        lat_clr  = 4'h0;
        next_s   = s;
        next_s.copy_held = 1'b0;
        wr_cur = 1'b0;
        wr_idx = s.idx;

        // byte placement into the current identifier
        if (byte_vld) begin
            if (!s.ctrl[CTL_RX_ALIGN]) begin
                wr_cur = 1'b1;  // [RULE10]
                wr_idx = s.idx;
                done = (s.idx == ID_LAST);
                next_s.idx = s.idx + 4'h1;
                next_s.aln = TTC_HUNT;
            end else if (s.aln == TTC_TRACK &&
                         first_bit == (s.idx == ID_FIRST)) begin
                wr_cur = 1'b1;  // [RULE9]
                wr_idx = s.idx;
                done = (s.idx == ID_LAST);
                next_s.idx = s.idx + 4'h1;
            end else if (first_bit) begin
                // a stray one restarts the check from this byte
                wr_cur = 1'b1;  // [RULE9] [RULE11]
                wr_idx = ID_FIRST;
                next_s.idx = ID_FIRST + 4'h1;
                next_s.aln = TTC_TRACK;
            end else begin
                next_s.idx = ID_FIRST;  // [RULE9]
                next_s.aln = TTC_HUNT;
            end
        end

        // running comparisons, restarted at the first byte
        if (wr_cur) begin
            base = (wr_idx == ID_FIRST);
            f_same = (base | s.acc_same) & (rx_byte == cur_mem[wr_idx]);
            f_zero = (base | s.acc_zero) & (rx_byte == BYTE_ZERO);
            f_held = (base | s.acc_held) & (rx_byte == held_mem[wr_idx]);
            next_s.acc_same = f_same;
            next_s.acc_zero = f_zero;
            next_s.acc_held = f_held;
        end

        // end of an identifier
        if (done) begin
            nz = ~f_zero;
            if (nz && f_same) begin
                same_n = (s.same_cnt == STABLE_RUN) ? STABLE_RUN
                                                    : s.same_cnt + 3'h1;
            end else begin
                same_n = {2'b00, nz};
            end
            zero_n = f_zero ? ((s.zero_cnt == STABLE_RUN) ? STABLE_RUN
                                : s.zero_cnt + 3'h1) : 3'h0;
            nz_n = nz ? ((s.nz_cnt == STABLE_RUN) ? STABLE_RUN
                         : s.nz_cnt + 3'h1) : 3'h0;
            miss = ~f_same & ~(s.held_valid & f_held);
            miss_n = miss ? ((s.miss_cnt == UNSTABLE_RUN) ? UNSTABLE_RUN
                             : s.miss_cnt + 4'h1) : 4'h0;
            next_s.same_cnt = same_n;
            next_s.zero_cnt = zero_n;
            next_s.nz_cnt = nz_n;
            next_s.miss_cnt = miss_n;
            if (same_n == STABLE_RUN && !(s.held_valid && f_held)) begin
                next_s.copy_held = 1'b1;  // [RULE12]
            end
            idle_set = (zero_n == STABLE_RUN);
            unst_set = (miss_n == UNSTABLE_RUN);
            // idle wins when both are declared on the same identifier
            if (idle_set) begin
                next_s.idle = 1'b1;  // [RULE13]
                next_s.unstable = 1'b0;  // [RULE14]
            end else begin
                if (unst_set) begin
                    next_s.unstable = 1'b1;  // [RULE14]
                    next_s.idle = 1'b0;  // [RULE13]
                    // misses are nonzero too: count five afresh from here
                    next_s.nz_cnt = 3'h0;  // [RULE14]
                end else if (nz_n == STABLE_RUN) begin
                    next_s.unstable = 1'b0;  // [RULE14]
                    next_s.idle = 1'b0;  // [RULE13]
                end
            end
        end

        if (s.copy_held) begin
            next_s.held_valid = 1'b1;  // [RULE17]
        end
        // mismatch only once a held identifier exists
        next_s.mismatch = cmp_on & s.held_valid & (|diff);  // [RULE17]

        // latched status, a set beats a clear in the same cycle
        lat_set[LAT_IDLE] = next_s.idle ^ s.idle;  // [RULE23]
        lat_set[LAT_UNSTABLE] = next_s.unstable ^ s.unstable;
        lat_set[LAT_MISMATCH] = next_s.mismatch ^ s.mismatch;
        lat_set[LAT_CHANGE] = next_s.copy_held;  // [RULE12]
        if (i_wr && i_addr == ADDR_LATCH) begin
            lat_clr = i_wdata[3:0];
        end
        next_s.latch = (s.latch & ~lat_clr) | lat_set;  // [RULE23]

        if (i_wr && i_addr == ADDR_CTRL) begin
            next_s.ctrl = i_wdata;
        end

        // read data stands only in the cycle after the strobe
        next_s.rdata = BYTE_ZERO;
        if (i_rd) begin
            case (page)
                PAGE_REG: begin
                    if (i_addr == ADDR_CTRL) begin
                        next_s.rdata = s.ctrl;
                    end else if (i_addr == ADDR_STAT) begin
                        next_s.rdata = {4'h0, s.held_valid, s.mismatch,
                                        s.unstable, s.idle};
                    end else if (i_addr == ADDR_LATCH) begin
                        next_s.rdata = {4'h0, s.latch};
                    end
                end
                PAGE_TX:   next_s.rdata = tx_rd;
                PAGE_CUR:  next_s.rdata = cur_mem[off];  // [RULE22]
                PAGE_HELD: next_s.rdata = held_mem[off];  // [RULE22]
                PAGE_EXP:  next_s.rdata = exp_mem[off];  // [RULE22]
                default:   next_s.rdata = BYTE_ZERO;
            endcase
        end
    end

    // storage arrays: no line clock needed for register access
    always_ff @(posedge i_ref_clk) begin  // [RULE20]
        if (wr_cur) begin
            cur_mem[wr_idx] <= rx_byte;  // [RULE11]
        end
        if (s.copy_held) begin
            held_mem <= cur_mem;  // [RULE12]
        end
        if (i_wr && page == PAGE_EXP) begin
            exp_mem[off] <= i_wdata;  // [RULE22]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!rst_n) begin
            s <= RX_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign o_rdata               = s.rdata;
    assign o_rx_idle             = s.idle;
    assign o_identifier_unstable = s.unstable;
    assign o_identifier_mismatch = s.mismatch;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n);

    AST_IDLE_FIVE: assert property ( // [RULE13]
        $rose(s.idle) |-> (s.zero_cnt == STABLE_RUN))
        else $error("idle without five zero identifiers");
    AST_UNSTABLE_EIGHT: assert property ( // [RULE14]
        $rose(s.unstable) |-> (s.miss_cnt == UNSTABLE_RUN))
        else $error("unstable without eight misses");
    AST_IDLE_UNSTABLE_EXCL: assert property ( // [RULE13] [RULE14]
        !(s.idle && s.unstable))
        else $error("idle and unstable together");
    AST_NO_TIM_INVALID: assert property ( // [RULE17]
        !s.held_valid |-> !s.mismatch)
        else $error("mismatch before first update");
    AST_TIM_OFF_NOALIGN: assert property ( // [RULE16]
        !s.ctrl[CTL_RX_ALIGN] |=> !s.mismatch)
        else $error("mismatch with alignment off");
    AST_HELD_UPDATE: assert property ( // [RULE12]
        s.copy_held |-> (s.same_cnt == STABLE_RUN) ##1
        (s.held_valid && held_mem[0] == $past(cur_mem[0])))
        else $error("held identifier update wrong");
    AST_CHANGE_LATCHED: assert property ( // [RULE23]
        s.copy_held |-> s.latch[LAT_CHANGE])
        else $error("identifier change not latched");
    AST_ALIGN_OFF_SEQ: assert property ( // [RULE10]
        (byte_vld && !s.ctrl[CTL_RX_ALIGN]) |=>
        (s.idx == $past(s.idx) + 4'h1))
        else $error("bytes not stored in sequence");
    AST_FIRST_AT_ZERO: assert property ( // [RULE11]
        (wr_cur && s.ctrl[CTL_RX_ALIGN] && first_bit) |->
        (wr_idx == ID_FIRST))
        else $error("aligned first byte not at location zero");
    AST_UNSTABLE_END: assert property ( // [RULE14]
        $fell(s.unstable) |-> (s.idle || s.nz_cnt == STABLE_RUN))
        else $error("unstable ended without cause");
    AST_IDLE_END: assert property ( // [RULE13]
        $fell(s.idle) |-> (s.unstable || s.nz_cnt == STABLE_RUN))
        else $error("idle ended without cause");
    AST_LATCH_IDLE: assert property ( // [RULE23]
        $changed(s.idle) |-> s.latch[LAT_IDLE])
        else $error("idle change not latched");
    AST_LATCH_UNSTABLE: assert property ( // [RULE23]
        $changed(s.unstable) |-> s.latch[LAT_UNSTABLE])
        else $error("unstable change not latched");

    COV_HELD_UPDATE: cover property (s.copy_held);
    COV_IDLE: cover property ($rose(s.idle));
    COV_UNSTABLE: cover property ($rose(s.unstable));
    COV_MISMATCH: cover property ($rose(s.mismatch));
    COV_UNSTABLE_END: cover property ($fell(s.unstable));
endmodule : ttc_trail_trace

// file: verilog/ttc_pkg.sv
// constants, state types and register layout of the trail trace controller
package ttc_pkg;
    localparam int unsigned ID_BYTES     = 16;
    localparam logic [3:0]  ID_FIRST     = 4'h0;
    localparam logic [3:0]  ID_LAST      = 4'hF;
    localparam logic [2:0]  BIT_FIRST    = 3'h0;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam logic [2:0]  STABLE_RUN   = 3'h5;
    localparam logic [3:0]  UNSTABLE_RUN = 4'h8;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    // register page in addr[7:4], entry in addr[3:0]
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_STAT    = 8'h01;
    localparam logic [7:0]  ADDR_LATCH   = 8'h02;
    localparam logic [3:0]  PAGE_REG     = 4'h0;
    localparam logic [3:0]  PAGE_TX      = 4'h1;
    localparam logic [3:0]  PAGE_CUR     = 4'h2;
    localparam logic [3:0]  PAGE_HELD    = 4'h3;
    localparam logic [3:0]  PAGE_EXP     = 4'h4;
    // control bits
    localparam int unsigned CTL_TX_ALIGN   = 0;
    localparam int unsigned CTL_TX_REORDER = 1;
    localparam int unsigned CTL_TX_INVERT  = 2;
    localparam int unsigned CTL_TX_IDLE    = 3;
    localparam int unsigned CTL_RX_INVERT  = 4;
    localparam int unsigned CTL_RX_ALIGN   = 5;
    localparam int unsigned CTL_RX_REORDER = 6;
    localparam int unsigned CTL_CMP_EN     = 7;
    // latched status bits
    localparam int unsigned LAT_IDLE     = 0;
    localparam int unsigned LAT_UNSTABLE = 1;
    localparam int unsigned LAT_MISMATCH = 2;
    localparam int unsigned LAT_CHANGE   = 3;
    // alignment bit sits in bit 7, or in bit 0 when reordered
    localparam logic [7:0]  MASK_MSB_ALIGN = 8'h7F;
    localparam logic [7:0]  MASK_LSB_ALIGN = 8'hFE;

    typedef enum logic {TTC_HUNT, TTC_TRACK} ttc_aln_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rdata;
        logic [3:0] latch;
        ttc_aln_t   aln;
        logic [3:0] idx;
        logic       acc_same;
        logic       acc_zero;
        logic       acc_held;
        logic [2:0] same_cnt;
        logic [2:0] zero_cnt;
        logic [2:0] nz_cnt;
        logic [3:0] miss_cnt;
        logic       idle;
        logic       unstable;
        logic       mismatch;
        logic       held_valid;
        logic       copy_held;
    } ttc_rx_state_t;

    typedef struct packed {
        logic [3:0] idx;
        logic [2:0] bitn;
        logic       tx_bit;
    } ttc_tx_state_t;

    typedef struct packed {
        logic [6:0] sr;
        logic [2:0] cnt;
        logic       vld;
        logic [7:0] data;
        logic       first;
    } ttc_des_state_t;

    localparam ttc_rx_state_t  RX_RESET  = '0;
    localparam ttc_tx_state_t  TX_RESET  = '0;
    localparam ttc_des_state_t DES_RESET = '0;
endpackage : ttc_pkg

// file: verilog/ttc_rx_deser.sv
// receive bit collector: inversion, alarm forcing, byte assembly, reorder
`timescale 1ns/10ps
module ttc_rx_deser (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_bit,
    input  wire logic       i_bit_en,
    input  wire logic       i_invert,
    input  wire logic       i_force_ones,
    input  wire logic       i_reorder,
    output logic            o_byte_vld,
    output logic [7:0]      o_byte,
    output logic            o_first_bit
);
    import ttc_pkg::*;

    ttc_des_state_t s;
    ttc_des_state_t next_s;
    logic           b;
    logic [7:0]     full;
    logic [7:0]     rev;

    for (genvar g = 0; g < 8; g++) begin : g_rev
        assign rev[g] = full[7-g];
    end

    always_comb begin
        next_s = s;
        next_s.vld = 1'b0;
        b = i_force_ones ? 1'b1 : (i_bit ^ i_invert);  // [RULE8] [RULE19]
        full = {s.sr, b};  // first bit ends in bit 7 [RULE3]
        if (i_bit_en) begin
            next_s.sr = full[6:0];
            next_s.cnt = s.cnt + 3'h1;
            if (s.cnt == BIT_LAST) begin
                next_s.vld = 1'b1;
                next_s.data = i_reorder ? rev : full;  // [RULE18]
                next_s.first = full[7];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s <= DES_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign o_byte_vld  = s.vld;
    assign o_byte      = s.data;
    assign o_first_bit = s.first;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    AST_RX_FORCE_ONES: assert property ( // [RULE19]
        (i_bit_en && s.cnt == BIT_LAST && i_force_ones) |=>
        (o_byte_vld && (($past(i_reorder) ? o_byte[7] : o_byte[0]) == 1'b1)))
        else $error("forced last bit did not read as one");
    AST_RX_BIT_PLACE: assert property ( // [RULE18] [RULE3]
        (i_bit_en && s.cnt == BIT_LAST) |=>
        (o_first_bit == ($past(i_reorder) ? o_byte[0] : o_byte[7])))
        else $error("first received bit in wrong position");
    AST_RX_INVERT: assert property ( // [RULE8]
        (i_bit_en && s.cnt == BIT_LAST && !i_force_ones && !i_reorder) |=>
        (o_byte[0] == ($past(i_bit) ^ $past(i_invert))))
        else $error("receive inversion wrong");
endmodule : ttc_rx_deser

// file: verilog/ttc_tx_proc.sv
// transmit identifier store and serial trace processor
`timescale 1ns/10ps
module ttc_tx_proc (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_wr_en,
    input  wire logic [3:0] i_wr_idx,
    input  wire logic [7:0] i_wdata,
    input  wire logic [3:0] i_rd_idx,
    output logic [7:0]      o_rd_data,
    input  wire logic       i_bit_en,
    input  wire logic       i_align,
    input  wire logic       i_reorder,
    input  wire logic       i_invert,
    input  wire logic       i_idle,
    output logic            o_tx_bit
);
    import ttc_pkg::*;

    ttc_tx_state_t s;
    ttc_tx_state_t next_s;
    logic [7:0]    mem [ID_BYTES];
    logic [7:0]    byte_v;
    logic          raw;

    // no reset: contents survive both resets, random after power-up
    always_ff @(posedge i_ref_clk) begin  // [RULE2]
        if (i_wr_en) begin
            mem[i_wr_idx] <= i_wdata;  // write pointer from register side [RULE1]
        end
    end

    assign o_rd_data = mem[i_rd_idx];
    assign byte_v = mem[s.idx];  // read pointer of the line side [RULE1]

    always_comb begin
        next_s = s;
        raw = i_reorder ? byte_v[s.bitn] : byte_v[BIT_LAST - s.bitn]; // [RULE4]
        if (i_align && s.bitn == BIT_FIRST) begin
            raw = (s.idx == ID_FIRST);  // [RULE5]
        end
        if (i_idle) begin
            raw = 1'b0;  // [RULE7]
        end
        if (i_bit_en) begin
            next_s.tx_bit = raw ^ i_invert;  // [RULE6]
            next_s.bitn = s.bitn + 3'h1;
            if (s.bitn == BIT_LAST) begin
                next_s.idx = s.idx + 4'h1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s <= TX_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign o_tx_bit = s.tx_bit;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    logic b7;
    logic b0;
    assign b7 = byte_v[7];
    assign b0 = byte_v[0];

    AST_TX_IDLE: assert property ( // [RULE7] [RULE6]
        (i_bit_en && i_idle) |=> (o_tx_bit == $past(i_invert)))
        else $error("idle did not send zeros");
    AST_TX_ALIGN: assert property ( // [RULE5]
        (i_bit_en && i_align && !i_idle && s.bitn == BIT_FIRST) |=>
        (o_tx_bit == (($past(s.idx) == ID_FIRST) ^ $past(i_invert))))
        else $error("alignment bit wrong");
    AST_TX_ORDER: assert property ( // [RULE4] [RULE6]
        (i_bit_en && !i_align && !i_idle && s.bitn == BIT_FIRST) |=>
        (o_tx_bit == (($past(i_reorder) ? $past(b0) : $past(b7))
                      ^ $past(i_invert))))
        else $error("first transmitted bit from wrong position");
endmodule : ttc_tx_proc

// file: tb/ttc_line_model.sv
// line-side partner: trace stream source and sink
`timescale 1ns/10ps
module ttc_line_model (
    input  wire logic i_ref_clk,
    input  wire logic i_tx_bit,
    output logic      o_rx_bit,
    output logic      o_rx_en,
    output logic      o_tx_en
);
    initial {o_rx_bit, o_rx_en, o_tx_en} = 3'h0;
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge i_ref_clk);
            o_rx_bit <= b[i];
            o_rx_en  <= 1'h1;
            @(posedge i_ref_clk);
            o_rx_bit <= ~b[i]; // no stale copy between strobes
            o_rx_en  <= 1'h0;
        end
    endtask : send
    task automatic take(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge i_ref_clk);
            o_tx_en <= 1'h1;
            @(posedge i_ref_clk);
            o_tx_en <= 1'h0;
            @(posedge i_ref_clk);
            b[i] = i_tx_bit;
        end
    endtask : take
endmodule : ttc_line_model

// file: tb/ttc_trail_trace_tb.sv
// self-checking bench for the trail trace controller
`timescale 1ns/10ps
module ttc_trail_trace_tb;
    import ttc_pkg::*;
    logic        clk, rst_n, datapath_reset_n_n, wr, rd, rx_bit, rx_en, tx_en, tx_bit;
    logic        mism, idle, unst, sig, frm, alarm_indication;
    logic [7:0]  addr, wdata, rdata, g, e, id [16];
    logic [31:0] rxt [6] = '{32'h0001_00FF, 32'h0002_00FF, 32'h0004_00FF,
                             32'h1000_0FF0, 32'h4000_03C0, 32'h5000_033F};
    int          fails, num_checks;
    ttc_trail_trace dut_u (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_datapath_reset_n(datapath_reset_n_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_rx_bit(rx_bit), .i_rx_bit_en(rx_en),
        .i_signal_loss(sig), .i_frame_loss(frm), .i_alarm_indication(alarm_indication),
        .i_tx_bit_en(tx_en), .o_tx_bit(tx_bit), .o_rx_idle(idle),
        .o_identifier_unstable(unst), .o_identifier_mismatch(mism));
    ttc_line_model line_u (
        .i_ref_clk(clk), .i_tx_bit(tx_bit), .o_rx_bit(rx_bit),
        .o_rx_en(rx_en), .o_tx_en(tx_en));
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // reads wait a little so line-driven status has settled
    task automatic acc(input logic w, input logic [7:0] a, d);
        if (!w) repeat (3) @(posedge clk);
        @(posedge clk);
        addr     <= a;
        wdata    <= d;
        {wr, rd} <= {w, !w};
        @(posedge clk);
        {wr, rd} <= 2'h0;
        if (!w) #1 chk(rdata, d);
    endtask : acc
    task automatic tx_run(input logic [7:0] c);
        acc(1, ADDR_CTRL, c);
        foreach (id[i]) begin
            e = id[i];
            if (c[CTL_TX_REORDER]) e = {<<{id[i]}};
            if (c[CTL_TX_ALIGN]) e[7] = (i == 0);
            if (c[CTL_TX_IDLE]) e = BYTE_ZERO;
            if (c[CTL_TX_INVERT]) e = ~e;
            line_u.take(g);
            chk(g, e);
        end
    endtask : tx_run
    task automatic give_verdict(input int late);
        fails += late;
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    initial begin
        {rst_n, datapath_reset_n_n, wr, rd, sig, frm, alarm_indication, clk, addr, wdata} = 24'h40_0000;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        acc(0, 8'hF3, BYTE_ZERO);
        foreach (id[i]) begin
            id[i] = 8'h5A ^ 8'(i * 29);
            acc(1, {PAGE_TX, 4'(i)}, id[i]);
        end
        for (int k = 0; k < 16; k++) tx_run(8'(k));
        datapath_reset_n_n <= 1'h0;
        repeat (16) @(posedge clk);
        datapath_reset_n_n <= 1'h1;
        tx_run(8'h02);
        foreach (id[i]) begin
            id[i] = {i == 0, 7'(8'h30 + i)};
            acc(1, {PAGE_EXP, 4'(i)}, id[i] ^ {7'h00, i == 3});
        end
        acc(1, ADDR_CTRL, 8'hA0);
        line_u.send(8'h55);
        repeat (3) foreach (id[i]) line_u.send(id[i]);
        chk({7'h00, mism}, BYTE_ZERO);
        repeat (3) foreach (id[i]) line_u.send(id[i]);
        foreach (id[i])
            acc(0, {PAGE_HELD, 4'(i)}, id[i]);
        acc(0, ADDR_STAT, 8'h0C);
        chk({7'h00, mism}, 8'h01);
        acc(0, ADDR_LATCH, 8'h0C);
        acc(1, ADDR_LATCH, 8'h0C);
        acc(0, ADDR_LATCH, 8'h00);
        acc(1, {PAGE_EXP, 4'h3}, id[3] ^ 8'h80);
        acc(0, ADDR_STAT, 8'h08);
        acc(1, {PAGE_EXP, 4'h3}, id[3] ^ 8'h01);
        for (int k = 1; k < 9; k++) foreach (id[i]) line_u.send(id[i] + 8'(k));
        acc(0, ADDR_STAT, 8'h0E);
        chk({6'h00, unst, idle}, 8'h02);
        acc(0, ADDR_LATCH, 8'h06);
        repeat (4) foreach (id[i]) line_u.send(id[i] + 8'h08);
        acc(0, ADDR_STAT, 8'h0E);
        foreach (id[i]) line_u.send(id[i] + 8'h08);
        acc(0, ADDR_STAT, 8'h0C);
        chk({6'h00, unst, idle}, 8'h00);
        acc(1, ADDR_CTRL, 8'h80);
        repeat (96) line_u.send(BYTE_ZERO);
        acc(0, ADDR_STAT, 8'h09);
        chk({6'h00, unst, idle}, 8'h01);
        foreach (rxt[k]) begin
            acc(1, ADDR_CTRL, rxt[k][31:24]);
            {alarm_indication, frm, sig} <= rxt[k][18:16];
            repeat (16) line_u.send(rxt[k][15:8]);
            acc(0, {PAGE_CUR, 4'h7}, rxt[k][7:0]);
        end
        give_verdict(0);
    end
    initial #1ms give_verdict(1); // over twice the expected run
endmodule : ttc_trail_trace_tb
